// >>> logic/uep_ep0_ctrl.sv
// Summary of operation
// - Each of endpoints 1 to 7 has a mask bit: 0 passes its NAK flag to the NAK pin, 1 blocks it.
// - A masked endpoint still gets its NAK flag set on a NAK, but never raises the NAK pin.
// - The NAK flag of endpoints 1 to 7 is set whenever that endpoint sends a NAK handshake.
// - Bit 15 of the packet-size word is set by the zero-length command, cleared once it is sent.
// - Bit 12 of the packet-size word shows valid FIFO data and is cleared by every SETUP token.
// - Bits 6..0 hold the writable max packet size and bits 11..7 always read zero.
// - The write-block flag, bit 15 of the state word, sets on SETUP and clears on setup-ack.
// - While the write-block flag is 1, and in the SETUP cycle, writes to the control FIFO are dropped, else accepted.
// - Bits 13..12 of the state word show the toggle: 00 DATA0, 01 DATA1, others never used.
// - Bits 11..9 of the state word show the endpoint state, forced to Ready by every SETUP.
// - The state goes to Busy when the endpoint answered NAK in the status stage.
// - The state goes to Error on a received CRC error or a response timeout after sending.
// - A control read asking past the requested length returns STALL and sets state Stall.
//
// Decided for this implementation: the register addresses and the Wishbone slave port.
`default_nettype none
module uep_ep0_ctrl #(
    parameter int unsigned EP_LAST = uep_pkg::EP_LAST
) (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               ce_i,
    // Wishbone classic slave
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    // Link events, one-cycle pulses
    input  wire logic               setup_tok_i,
    input  wire logic [EP_LAST:1]   nak_sent_i,
    input  wire logic               status_nak_i,
    input  wire logic               crc_err_i,
    input  wire logic               resp_timeout_i,
    input  wire logic               over_read_i,
    input  wire logic               data_acked_i,
    input  wire logic               zlp_sent_i,
    input  wire logic               rx_data_stored_i,
    input  wire logic               fifo_drained_i,
    // Control FIFO write path
    input  wire logic               fifo_wr_req_i,
    output logic                    fifo_wr_accept_o,
    // Link requests
    output logic                    zlp_pending_o,
    output logic                    stall_o,
    // Interrupts
    output logic                    nak_int_o,
    output logic                    irq_o
);
    if (EP_LAST < 1 || EP_LAST > 7) begin : g_bad_ep_last
        $error("EP_LAST must lie between 1 and 7");
    end

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr[7:2] == off[7:2]);
    endfunction

    uep_reg_if regs ();

    uep_wb_slave u_wb (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .ce_i     (ce_i),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_i (wb_dat_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .regs     (regs)
    );

    // Byte lane 0 carries every writable field
    logic wr0;
    assign wr0 = regs.wr && regs.sel[0];

    // NAK flags and mask
    logic [EP_LAST:1] nak_mask, next_nak_mask;
    logic [EP_LAST:1] nak_stat, next_nak_stat;
    logic             nak_int, next_nak_int;

    // Clear is write-one; a NAK in the same cycle keeps the flag set
    for (genvar k = 1; k <= EP_LAST; k++) begin : g_nak
        always_comb begin
            next_nak_stat[k] = nak_stat[k];
            if (wr0 && hit(regs.addr, uep_pkg::OFF_NAK_STAT) && regs.wdata[k]) begin
                next_nak_stat[k] = 1'b0;
            end
            if (nak_sent_i[k]) begin
                next_nak_stat[k] = 1'b1;
            end
        end
    end

    always_comb begin
        next_nak_mask = nak_mask;
        if (wr0 && hit(regs.addr, uep_pkg::OFF_NAK_MASK)) begin
            next_nak_mask = regs.wdata[EP_LAST:1];
        end
        next_nak_int = |(nak_stat & ~nak_mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nak_mask <= uep_pkg::NAK_MASK_RST[EP_LAST:1];
            nak_stat <= '0;
            nak_int  <= 1'b0;
        end else if (ce_i) begin
            nak_mask <= next_nak_mask;
            nak_stat <= next_nak_stat;
            nak_int  <= next_nak_int;
        end
    end

    // Packet size word and FIFO gating
    logic [6:0] max_pkt, next_max_pkt;
    logic       zlp_pend, next_zlp_pend;
    logic       dset, next_dset;
    logic       wr_block, next_wr_block;
    logic       wr_accept, next_wr_accept;
    logic       cmd_wr;

    assign cmd_wr = wr0 && hit(regs.addr, uep_pkg::OFF_COMMAND);

    always_comb begin
        next_max_pkt = max_pkt;
        if (wr0 && hit(regs.addr, uep_pkg::OFF_PKT_SIZE)) begin
            next_max_pkt = regs.wdata[uep_pkg::MAX_PKT_W-1:0];
        end
        next_zlp_pend = zlp_pend;
        if (zlp_sent_i) begin
            next_zlp_pend = 1'b0;
        end
        if (cmd_wr && regs.wdata[uep_pkg::CMD_ZLP_BIT]) begin
            next_zlp_pend = 1'b1;
        end
        next_wr_block = wr_block;
        if (cmd_wr && regs.wdata[uep_pkg::CMD_SACK_BIT]) begin
            next_wr_block = 1'b0;
        end
        if (setup_tok_i) begin
            next_wr_block = 1'b1;
        end
        // A request in the SETUP cycle is dropped as well: the block is already due
        next_wr_accept = fifo_wr_req_i && !wr_block && !setup_tok_i;
        next_dset = dset;
        if (fifo_drained_i) begin
            next_dset = 1'b0;
        end
        if (rx_data_stored_i || next_wr_accept) begin
            next_dset = 1'b1;
        end
        if (setup_tok_i) begin
            next_dset = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            max_pkt   <= uep_pkg::MAX_PKT_RST;
            zlp_pend  <= 1'b0;
            wr_block  <= 1'b0;
            wr_accept <= 1'b0;
            dset      <= 1'b0;
        end else if (ce_i) begin
            max_pkt   <= next_max_pkt;
            zlp_pend  <= next_zlp_pend;
            wr_block  <= next_wr_block;
            wr_accept <= next_wr_accept;
            dset      <= next_dset;
        end
    end

    // Endpoint state and toggle; SETUP outranks every other event
    uep_pkg::uep_ep0_state_t ep_state, next_ep_state;
    logic [1:0]              toggle, next_toggle;
    logic                    stall, next_stall;

    always_comb begin
        next_ep_state = ep_state;
        next_toggle   = toggle;
        next_stall    = 1'b0;
        case (ep_state)
            uep_pkg::EP0_READY, uep_pkg::EP0_BUSY,
            uep_pkg::EP0_ERROR, uep_pkg::EP0_STALL: begin
                if (status_nak_i) begin
                    next_ep_state = uep_pkg::EP0_BUSY;
                end
                if (crc_err_i || resp_timeout_i) begin
                    next_ep_state = uep_pkg::EP0_ERROR;
                end
                if (over_read_i) begin
                    next_ep_state = uep_pkg::EP0_STALL;
                    next_stall    = 1'b1;
                end
            end
            default: next_ep_state = uep_pkg::EP0_READY;
        endcase
        if (data_acked_i) begin
            next_toggle = (toggle == uep_pkg::TOG_DATA0) ? uep_pkg::TOG_DATA1
                                                         : uep_pkg::TOG_DATA0;
        end
        if (setup_tok_i) begin
            next_ep_state = uep_pkg::EP0_READY;
            next_toggle   = uep_pkg::TOG_DATA0;
            next_stall    = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ep_state <= uep_pkg::EP0_READY;
            toggle   <= uep_pkg::TOG_DATA0;
            stall    <= 1'b0;
        end else if (ce_i) begin
            ep_state <= next_ep_state;
            toggle   <= next_toggle;
            stall    <= next_stall;
        end
    end

    // Interrupt status, enable and level output
    logic [uep_pkg::IRQ_W-1:0] irq_stat, next_irq_stat;
    logic [uep_pkg::IRQ_W-1:0] irq_en, next_irq_en;
    logic [uep_pkg::IRQ_W-1:0] irq_evt;
    logic                      irq, next_irq;

    always_comb begin
        irq_evt                         = '0;
        irq_evt[uep_pkg::IRQ_SETUP]     = setup_tok_i;
        irq_evt[uep_pkg::IRQ_ZLP_DONE]  = zlp_sent_i && zlp_pend;
        irq_evt[uep_pkg::IRQ_ERROR]     = crc_err_i || resp_timeout_i;
        irq_evt[uep_pkg::IRQ_STALL]     = over_read_i;
        next_irq_stat = irq_stat;
        if (wr0 && hit(regs.addr, uep_pkg::OFF_IRQ_CLR)) begin
            next_irq_stat = irq_stat & ~regs.wdata[uep_pkg::IRQ_W-1:0];
        end
        next_irq_stat = next_irq_stat | irq_evt;
        next_irq_en   = irq_en;
        if (wr0 && hit(regs.addr, uep_pkg::OFF_IRQ_EN)) begin
            next_irq_en = regs.wdata[uep_pkg::IRQ_W-1:0];
        end
        next_irq = |(irq_stat & irq_en);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= '0;
            irq_en   <= '0;
            irq      <= 1'b0;
        end else if (ce_i) begin
            irq_stat <= next_irq_stat;
            irq_en   <= next_irq_en;
            irq      <= next_irq;
        end
    end

    // Read mux; unmapped and write-only words read zero
    always_comb begin
        regs.rdata = 32'h0000_0000;
        if (hit(regs.addr, uep_pkg::OFF_NAK_MASK)) begin
            regs.rdata[EP_LAST:1] = nak_mask;
        end else if (hit(regs.addr, uep_pkg::OFF_NAK_STAT)) begin
            regs.rdata[EP_LAST:1] = nak_stat;
        end else if (hit(regs.addr, uep_pkg::OFF_PKT_SIZE)) begin
            regs.rdata[uep_pkg::ZLP_BIT]             = zlp_pend;
            regs.rdata[uep_pkg::DSET_BIT]            = dset;
            regs.rdata[uep_pkg::MAX_PKT_W-1:0]       = max_pkt;
        end else if (hit(regs.addr, uep_pkg::OFF_EP0_STATE)) begin
            regs.rdata[uep_pkg::BLOCK_BIT]           = wr_block;
            regs.rdata[uep_pkg::TOG_LSB+:2]          = toggle;
            regs.rdata[uep_pkg::STATE_LSB+:3]        = ep_state;
        end else if (hit(regs.addr, uep_pkg::OFF_IRQ_STAT)) begin
            regs.rdata[uep_pkg::IRQ_W-1:0]           = irq_stat;
        end else if (hit(regs.addr, uep_pkg::OFF_IRQ_EN)) begin
            regs.rdata[uep_pkg::IRQ_W-1:0]           = irq_en;
        end
    end

    assign nak_int_o        = nak_int;
    assign irq_o            = irq;
    assign fifo_wr_accept_o = wr_accept;
    assign zlp_pending_o    = zlp_pend;
    assign stall_o          = stall;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_nak_pin_gate: assert property (ce_i
        |=> nak_int_o == |($past(nak_stat) & ~$past(nak_mask)))
        else $error("NAK pin does not follow unmasked flags");
    a_masked_nak_set: assert property (ce_i && |(nak_sent_i & nak_mask)
        |=> &(nak_stat | ~($past(nak_sent_i) & $past(nak_mask))))
        else $error("Masked endpoint lost its NAK flag");
    a_nak_flag_set: assert property (ce_i && |nak_sent_i
        |=> &(nak_stat | ~$past(nak_sent_i)))
        else $error("NAK sent but no flag set");
    sequence s_zlp_cmd;
        ce_i && cmd_wr && regs.wdata[uep_pkg::CMD_ZLP_BIT];
    endsequence
    sequence s_zlp_wait;
        (zlp_pending_o && !zlp_sent_i) [*1];
    endsequence
    a_zlp_pending: assert property (s_zlp_cmd |=> s_zlp_wait or (zlp_pending_o && zlp_sent_i))
        else $error("Zero-length command did not raise pending");
    a_zlp_clear: assert property (ce_i && zlp_sent_i && !cmd_wr |=> !zlp_pending_o)
        else $error("Pending flag not cleared after zero-length send");
    a_dset_setup: assert property (ce_i && setup_tok_i |=> !dset)
        else $error("Valid-data flag survived SETUP");
    a_size_zero_bits: assert property (wb_ack_o && !wb_we_i
        && hit(wb_adr_i, uep_pkg::OFF_PKT_SIZE) |-> wb_dat_o[11:7] == 5'h00)
        else $error("Packet size bits 11..7 read nonzero");
    a_block_setup: assert property (ce_i && setup_tok_i |=> wr_block)
        else $error("Write block not set by SETUP");
    a_fifo_discard: assert property (ce_i && wr_block && fifo_wr_req_i |=> !fifo_wr_accept_o)
        else $error("FIFO write accepted while blocked");
    a_toggle_legal: assert property (toggle[1] == 1'b0)
        else $error("Reserved toggle code shown");
    a_state_setup: assert property (ce_i && setup_tok_i |=> ep_state == uep_pkg::EP0_READY)
        else $error("State not Ready after SETUP");
    a_state_busy: assert property (ce_i && status_nak_i && !setup_tok_i && !crc_err_i
        && !resp_timeout_i && !over_read_i |=> ep_state == uep_pkg::EP0_BUSY)
        else $error("State not Busy after status-stage NAK");
    a_state_error: assert property (ce_i && (crc_err_i || resp_timeout_i)
        && !setup_tok_i && !over_read_i |=> ep_state == uep_pkg::EP0_ERROR)
        else $error("State not Error after CRC error or timeout");
    a_state_stall: assert property (ce_i && over_read_i && !setup_tok_i
        |=> ep_state == uep_pkg::EP0_STALL && stall_o)
        else $error("Over-read did not stall");
    a_toggle_flip: assert property (ce_i && data_acked_i && !setup_tok_i
        |=> toggle != $past(toggle))
        else $error("Toggle did not flip on acknowledged packet");
endmodule
`default_nettype wire

// >>> common/uep_pkg.sv
`default_nettype none
package uep_pkg;
    // Register map, byte offsets on the Wishbone bus
    localparam int unsigned ADDR_W        = 8;
    localparam logic [7:0]  OFF_NAK_MASK  = 8'h00;
    localparam logic [7:0]  OFF_PKT_SIZE  = 8'h04;
    localparam logic [7:0]  OFF_EP0_STATE = 8'h08;
    localparam logic [7:0]  OFF_NAK_STAT  = 8'h0c;
    localparam logic [7:0]  OFF_COMMAND   = 8'h10;
    localparam logic [7:0]  OFF_IRQ_STAT  = 8'h14;
    localparam logic [7:0]  OFF_IRQ_CLR   = 8'h18;
    localparam logic [7:0]  OFF_IRQ_EN    = 8'h1c;

    // Field positions
    localparam int unsigned EP_LAST       = 7;
    localparam int unsigned MAX_PKT_W     = 7;
    localparam int unsigned DSET_BIT      = 12;
    localparam int unsigned ZLP_BIT       = 15;
    localparam int unsigned BLOCK_BIT     = 15;
    localparam int unsigned TOG_LSB       = 12;
    localparam int unsigned STATE_LSB     = 9;
    localparam int unsigned CMD_ZLP_BIT   = 0;
    localparam int unsigned CMD_SACK_BIT  = 1;
    localparam int unsigned IRQ_W         = 4;
    localparam int unsigned IRQ_SETUP     = 0;
    localparam int unsigned IRQ_ZLP_DONE  = 1;
    localparam int unsigned IRQ_ERROR     = 2;
    localparam int unsigned IRQ_STALL     = 3;

    // Reset values and encodings
    localparam logic [6:0]  MAX_PKT_RST   = 7'h00;
    localparam logic [7:1]  NAK_MASK_RST  = 7'h00;
    localparam logic [1:0]  TOG_DATA0     = 2'h0;
    localparam logic [1:0]  TOG_DATA1     = 2'h1;

    typedef enum logic [2:0] {
        EP0_READY,
        EP0_BUSY,
        EP0_ERROR,
        EP0_STALL
    } uep_ep0_state_t;
endpackage
`default_nettype wire

// >>> common/uep_reg_if.sv
`default_nettype none
interface uep_reg_if;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  sel;
    logic        wr;
    logic [31:0] rdata;

    modport bus  (output addr, output wdata, output sel, output wr, input rdata);
    modport regs (input addr, input wdata, input sel, input wr, output rdata);
endinterface
`default_nettype wire

// >>> logic/uep_wb_slave.sv
`default_nettype none
module uep_wb_slave (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Register side
    uep_reg_if.bus           regs
);
    logic        ack;
    logic        next_ack;
    logic [31:0] dat;
    logic [31:0] next_dat;
    logic        take;

    assign take = wb_cyc_i && wb_stb_i && !ack;

    // Writes land on the edge that samples ack, as the master expects
    assign regs.wr    = wb_cyc_i && wb_stb_i && wb_we_i && ack;
    assign regs.addr  = wb_adr_i;
    assign regs.wdata = wb_dat_i;
    assign regs.sel   = wb_sel_i;

    always_comb begin
        next_ack = take;
        next_dat = dat;
        if (take) begin
            next_dat = wb_we_i ? 32'h0000_0000 : regs.rdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
            dat <= 32'h0000_0000;
        end else if (ce_i) begin
            ack <= next_ack;
            dat <= next_dat;
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = dat;
endmodule
`default_nettype wire

// >>> test/uep_link_model.sv
`default_nettype none
// Stands for the USB link side: turns one requested bus event into a one-cycle pulse
module uep_link_model (
    // Clock
    input  wire logic       clk_i,
    // Event pulses towards the endpoint logic
    output logic      [8:0] ev_o,
    output logic      [7:1] nak_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        ev_o  = '0;
        nak_o = '0;
    end

    // Pulses last exactly one cycle, as the link side raises each event once
    task automatic send(input int k, input logic [7:1] n);
        @(posedge clk_i);
        if (k >= 0) begin
            ev_o[k] <= 1'b1;
        end
        nak_o <= n;
        @(posedge clk_i);
        ev_o  <= '0;
        nak_o <= '0;
    endtask
endmodule
`default_nettype wire

// >>> test/uep_ep0_ctrl_test.sv
`default_nettype none
module uep_ep0_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i;
    logic        rst_i;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat_w;
    logic [31:0] dat_r;
    logic        ack;
    logic [8:0]  ev;
    logic [7:1]  nak;
    logic        fifo_req;
    logic        accept;
    logic        zlp_pend;
    logic        stall;
    logic        nak_int;
    logic        irq;
    logic        stall_seen;
    logic [31:0] rd;
    logic [31:0] v;
    logic [6:0]  m;
    logic [6:0]  n;
    int          failures;
    int          n_checks;
    int          seed;
    int          cycles;

    uep_link_model uep_link_model_inst (.clk_i(clk_i), .ev_o(ev), .nak_o(nak));

    uep_ep0_ctrl uep_ep0_ctrl_inst (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .setup_tok_i(ev[0]), .nak_sent_i(nak), .status_nak_i(ev[1]),
        .crc_err_i(ev[2]), .resp_timeout_i(ev[3]), .over_read_i(ev[4]),
        .data_acked_i(ev[5]), .zlp_sent_i(ev[6]), .rx_data_stored_i(ev[7]),
        .fifo_drained_i(ev[8]), .fifo_wr_req_i(fifo_req),
        .fifo_wr_accept_o(accept), .zlp_pending_o(zlp_pend), .stall_o(stall),
        .nak_int_o(nak_int), .irq_o(irq)
    );

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    function automatic logic [31:0] sts(input logic blk, input logic [1:0] tog,
                                        input logic [2:0] st);
        return {16'h0000, blk, 1'b0, tog, st, 9'h000};
    endfunction

    function automatic logic [2:0] st_for(input int k);
        case (k)
            1:       return uep_pkg::EP0_BUSY;
            4:       return uep_pkg::EP0_STALL;
            default: return uep_pkg::EP0_ERROR;
        endcase
    endfunction

    task automatic tally_and_finish();
        if (failures == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Classic single cycle; values read just after an edge are those before it
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        dat_w <= d;
        sel   <= 4'hf;
        @(posedge clk_i);
        while (ack !== 1'b1) begin
            @(posedge clk_i);
        end
        rd  = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    // Stall pulse is caught in the one cycle it stands
    task automatic event_in(input int k, input logic [7:1] nv);
        uep_link_model_inst.send(k, nv);
        @(posedge clk_i);
        stall_seen = stall;
        @(posedge clk_i);
    endtask

    task automatic fifo_write(output logic ok);
        @(posedge clk_i);
        fifo_req <= 1'b1;
        @(posedge clk_i);
        fifo_req <= 1'b0;
        @(posedge clk_i);
        ok = accept;
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end

    initial begin
        logic ok;
        logic [7:0] addrs [7];
        addrs = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h1c, 8'h20};
        seed = 42;
        {cyc, stb, we, adr, sel, dat_w, fifo_req} = '0;
        {failures, n_checks, cycles} = '0;
        rst_i = 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (addrs[i]) begin
            wb(1'b0, addrs[i], 32'h0);
            chk(rd, 32'h0);
        end
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 32'hffffffff : $random(seed);
            wb(1'b1, 8'h04, v);
            wb(1'b0, 8'h04, 32'h0);
            chk(rd, {25'h0, v[6:0]});
        end
        event_in(7, 7'h00);
        wb(1'b0, 8'h04, 32'h0);
        chk(rd, {19'h0, 1'b1, 5'h00, v[6:0]});
        wb(1'b1, 8'h10, 32'h1);
        wb(1'b0, 8'h04, 32'h0);
        chk(rd, {16'h0, 1'b1, 2'h0, 1'b1, 5'h00, v[6:0]});
        chk_bit(zlp_pend, 1'b1);
        event_in(6, 7'h00);
        wb(1'b0, 8'h04, 32'h0);
        chk(rd, {19'h0, 1'b1, 5'h00, v[6:0]});
        event_in(0, 7'h00);
        wb(1'b0, 8'h04, 32'h0);
        chk(rd, {25'h0, v[6:0]});
        wb(1'b0, 8'h08, 32'h0);
        chk(rd, sts(1'b1, uep_pkg::TOG_DATA0, uep_pkg::EP0_READY));
        fifo_write(ok);
        chk_bit(ok, 1'b0);
        wb(1'b1, 8'h10, 32'h2);
        wb(1'b0, 8'h08, 32'h0);
        chk(rd, sts(1'b0, uep_pkg::TOG_DATA0, uep_pkg::EP0_READY));
        fifo_write(ok);
        chk_bit(ok, 1'b1);
        wb(1'b0, 8'h04, 32'h0);
        chk(rd, {19'h0, 1'b1, 5'h00, v[6:0]});
        event_in(8, 7'h00);
        wb(1'b0, 8'h04, 32'h0);
        chk(rd, {25'h0, v[6:0]});
        event_in(5, 7'h00);
        wb(1'b0, 8'h08, 32'h0);
        chk(rd, sts(1'b0, uep_pkg::TOG_DATA1, uep_pkg::EP0_READY));
        event_in(5, 7'h00);
        wb(1'b0, 8'h08, 32'h0);
        chk(rd, sts(1'b0, uep_pkg::TOG_DATA0, uep_pkg::EP0_READY));
        event_in(5, 7'h00);
        for (int i = 1; i < 5; i++) begin
            event_in(0, 7'h00);
            wb(1'b0, 8'h08, 32'h0);
            chk(rd, sts(1'b1, uep_pkg::TOG_DATA0, uep_pkg::EP0_READY));
            event_in(i, 7'h00);
            chk_bit(stall_seen, i == 4);
            wb(1'b0, 8'h08, 32'h0);
            chk(rd, sts(1'b1, uep_pkg::TOG_DATA0, st_for(i)));
        end
        for (int i = 0; i < 5; i++) begin
            m = (i == 0) ? 7'h7f : (i == 1) ? 7'h00 : 7'($random(seed));
            n = (i < 2) ? 7'h7f : 7'($random(seed));
            wb(1'b1, 8'h00, {24'h0, m, 1'b0});
            wb(1'b0, 8'h00, 32'h0);
            chk(rd, {24'h0, m, 1'b0});
            event_in(-1, n);
            wb(1'b0, 8'h0c, 32'h0);
            chk(rd, {24'h0, n, 1'b0});
            chk_bit(nak_int, |(n & ~m));
            wb(1'b1, 8'h0c, 32'h000000fe);
            repeat (2) @(posedge clk_i);
            chk_bit(nak_int, 1'b0);
        end
        // Every interrupt source has fired by now and none was cleared
        wb(1'b1, 8'h1c, 32'h0);
        repeat (2) @(posedge clk_i);
        chk_bit(irq, 1'b0);
        wb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h0000000f);
        wb(1'b1, 8'h1c, 32'h1);
        repeat (2) @(posedge clk_i);
        chk_bit(irq, 1'b1);
        wb(1'b1, 8'h18, 32'hf);
        repeat (2) @(posedge clk_i);
        chk_bit(irq, 1'b0);
        wb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
